/* File: iaa_pkg.sv */
package iaa_pkg;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          FLAGS_W      = 7;
    localparam int          CTRL_W       = 2;
    localparam int          ADRCFG_W     = 9;
    localparam int          EXP_W        = 8;
    localparam int          WAIT_W       = 8;
    localparam int          EXT_REGS     = 8;
    localparam int          MEM_WAIT_DEF = 1;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_OPA      = 8'h08;
    localparam logic [7:0]  OFF_OPB      = 8'h0C;
    localparam logic [7:0]  OFF_CMD      = 8'h10;
    localparam logic [7:0]  OFF_ADRCFG   = 8'h14;
    localparam logic [7:0]  OFF_FEXP     = 8'h18;
    localparam logic [7:0]  OFF_RESULT   = 8'h1C;
    localparam logic [7:0]  OFF_STORE    = 8'h20;
    localparam logic [7:0]  OFF_INFO     = 8'h24;
    localparam logic [7:0]  OFF_RF_BASE  = 8'h40;
    // status word flag positions
    localparam int          FLG_C        = 0;
    localparam int          FLG_V        = 1;
    localparam int          FLG_Z        = 2;
    localparam int          FLG_N        = 3;
    localparam int          FLG_UF       = 4;
    localparam int          FLG_LV       = 5;
    localparam int          FLG_LUF      = 6;
    // control bits
    localparam int          CTRL_SAT     = 0;
    localparam int          CTRL_LATE    = 1;
    // command fields
    localparam int          CMD_OP_LSB   = 0;
    localparam int          CMD_M1_LSB   = 4;
    localparam int          CMD_M2_LSB   = 6;
    localparam int          CMD_DST_LSB  = 8;
    localparam int          CMD_SRC3_LSB = 13;
    localparam int          CMD_SRC_LSB  = 16;
    localparam int          CMD_SRC1_LSB = 24;
    // addressing config fields
    localparam int          ADR_DISP_LSB = 0;
    localparam int          ADR_INDEX    = 8;
    // reset values and limits
    localparam logic [1:0]  CTRL_RST     = 2'h0;
    localparam logic [6:0]  STATUS_RST   = 7'h00;
    localparam logic [4:0]  REG_NUM_MAX  = 5'h1B;
    localparam logic [7:0]  DISP_SHORT   = 8'h01;
    localparam logic [31:0] INT_MIN      = 32'h8000_0000;
    localparam logic [31:0] INT_MAX      = 32'h7FFF_FFFF;
    localparam logic [7:0]  FEXP_MAX     = 8'h7F;
    localparam logic [7:0]  FEXP_ZERO    = 8'h80;
    typedef enum logic [2:0] {OP_NONE, OP_INT_ABS, OP_INT_ABS_STORE, OP_ADD_WITH_CARRY_OP, OP_THREE_OPERAND_ADD_CARRY_OP,
                              OP_FLOAT_ABS_STORE} iaa_op_t;
    typedef enum logic [1:0] {SRC_REG, SRC_DIRECT, SRC_INDIRECT, SRC_IMMEDIATE} iaa_src_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} iaa_state_t;
endpackage

/* File: iaa_alu.sv */
`timescale 1ns/1ps
// Overview of operation
// - integer absolute value writes signed magnitude
// - most negative source saturates when mode set
// - most negative passes unchanged, overflow still flagged
// - flags change only for destinations R0-R7
// - sticky overflow sets on overflow; only reset or a status write clears it
// - overflow flag follows each operation's overflow
// - zero flag marks zero result
// - add-with-carry sums destination, source, carry
// - carry flag takes the carry out
// - add-with-carry negative flag; underflow cleared
// - saturate mode clamps overflowed integer results
// - general mode selects register/direct/indirect/immediate
// - paired form reads first, writes at end
// - store sees register value before modification
// - memory source read before the store
// - paired source indirect short; later revisions register
// - three-operand form sums both sources and carry
// - first source mode: bit0 selects indirect
// - second source mode: bit1 selects indirect
// - float absolute pair ignores saturate mode
module iaa_alu #(
    parameter int unsigned MEM_WAIT = iaa_pkg::MEM_WAIT_DEF
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        pce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [iaa_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [iaa_pkg::DATA_W-1:0]  pwdata,
    output logic                             pready,
    output logic      [iaa_pkg::DATA_W-1:0]  prdata,
    output logic                             pslverr,
    output logic                             store_strobe,
    output logic      [iaa_pkg::DATA_W-1:0]  store_value,
    output logic                             busy
);
    import iaa_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic reg_ok(input logic [4:0] n);
        return n <= REG_NUM_MAX;
    endfunction

    function automatic logic ext_reg(input logic [4:0] n);
        return n < 5'(EXT_REGS);
    endfunction

    function automatic logic is_mem(input logic [1:0] k);
        return (k == SRC_DIRECT) || (k == SRC_INDIRECT);
    endfunction

    // returns {legal, memory operand count}
    function automatic logic [2:0] cmd_check(input logic [31:0]         w,
                                             input logic [ADRCFG_W-1:0] a,
                                             input logic                late);
        logic [1:0] g;
        logic [1:0] t2;
        logic [4:0] d;
        logic [4:0] s;
        logic [4:0] s1;
        logic       short_ok;
        logic       ok;
        logic [1:0] mem;
        g        = w[CMD_M1_LSB +: 2];
        t2       = w[CMD_M2_LSB +: 2];
        d        = w[CMD_DST_LSB +: 5];
        s        = w[CMD_SRC_LSB +: 5];
        s1       = w[CMD_SRC1_LSB +: 5];
        short_ok = a[ADR_INDEX] || (a[ADR_DISP_LSB +: 8] <= DISP_SHORT);
        ok       = 1'h0;
        mem      = 2'h0;
        case (iaa_op_t'(w[CMD_OP_LSB +: 3]))
            OP_INT_ABS, OP_ADD_WITH_CARRY_OP: begin
                ok  = reg_ok(d) && ((g != SRC_REG) || reg_ok(s));
                mem = {1'h0, is_mem(g)};
            end
            OP_INT_ABS_STORE, OP_FLOAT_ABS_STORE: begin
                ok  = ext_reg(d) && (((g == SRC_INDIRECT) && short_ok)
                      || ((g == SRC_REG) && late && reg_ok(s)));
                mem = {1'h0, g == SRC_INDIRECT};
            end
            OP_THREE_OPERAND_ADD_CARRY_OP: begin
                ok  = reg_ok(d) && (g[0] ? short_ok : reg_ok(s1))
                      && (t2[1] ? short_ok : reg_ok(s));
                mem = {1'h0, g[0]} + {1'h0, t2[1]};
            end
            default: begin
                ok  = 1'h0;
                mem = 2'h0;
            end
        endcase
        return {ok, mem};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // storage
    iaa_state_t          state;
    logic [CTRL_W-1:0]   ctrl;
    logic [FLAGS_W-1:0]  status_word;
    logic [DATA_W-1:0]   opa;
    logic [DATA_W-1:0]   opb;
    logic [DATA_W-1:0]   cmd;
    logic [ADRCFG_W-1:0] adrcfg;
    logic [EXP_W-1:0]    fexp;
    logic [DATA_W-1:0]   result;
    logic [DATA_W-1:0]   rf [EXT_REGS];
    logic                illegal_cmd;
    logic [1:0]          last_mem;
    logic [WAIT_W-1:0]   wait_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic               wr_fire;
    logic               cmd_fire;
    logic               rf_hit;
    logic [2:0]         rf_idx;
    logic               mapped;
    logic [2:0]         chk;
    logic [WAIT_W-1:0]  wait_load;

    assign wr_fire   = pce && psel && penable && pready && pwrite && !pslverr;
    assign cmd_fire  = wr_fire && (paddr == OFF_CMD);
    assign rf_hit    = paddr[7:5] == OFF_RF_BASE[7:5];
    assign rf_idx    = paddr[4:2];
    assign chk       = cmd_check(pwdata, adrcfg, ctrl[CTRL_LATE]);
    assign wait_load = WAIT_W'(chk[1:0] * MEM_WAIT);

    always_comb begin
        mapped = (paddr[1:0] == 2'h0) && (rf_hit || (paddr <= OFF_INFO));
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded command
    iaa_op_t     op;
    logic [1:0]  m1;
    logic [1:0]  m2;
    logic [4:0]  dst_n;
    logic [4:0]  src_n;
    logic [4:0]  src1_n;
    logic [2:0]  src3_n;
    logic        exec;
    logic        paired;

    assign op     = iaa_op_t'(cmd[CMD_OP_LSB +: 3]);
    assign m1     = cmd[CMD_M1_LSB +: 2];
    assign m2     = cmd[CMD_M2_LSB +: 2];
    assign dst_n  = cmd[CMD_DST_LSB +: 5];
    assign src_n  = cmd[CMD_SRC_LSB +: 5];
    assign src1_n = cmd[CMD_SRC1_LSB +: 5];
    assign src3_n = cmd[CMD_SRC3_LSB +: 3];
    assign exec   = pce && (state == ST_EXEC);
    assign paired = (op == OP_INT_ABS_STORE) || (op == OP_FLOAT_ABS_STORE);

    ////////////////////////////////////////////////////////////////////////////
    // execute datapath, all operands sampled before any write
    logic              src_reg;
    logic              src1_reg;
    logic [31:0]       alu_a;
    logic [31:0]       alu_b;
    logic              carry_in;
    logic [33:0]       sum_s;
    logic [32:0]       sum_u;
    logic              ov;
    logic [31:0]       res;
    logic [31:0]       b_neg;
    logic              sat;
    logic [FLAGS_W-1:0] next_flags;

    always_comb begin
        src_reg  = (op == OP_THREE_OPERAND_ADD_CARRY_OP) ? !m2[1] : (m1 == SRC_REG);
        src1_reg = !m1[0];
        alu_b    = (src_reg && ext_reg(src_n)) ? rf[src_n[2:0]] : opb;
        if (op == OP_THREE_OPERAND_ADD_CARRY_OP) begin
            alu_a = (src1_reg && ext_reg(src1_n)) ? rf[src1_n[2:0]] : opa;
        end else begin
            alu_a = ext_reg(dst_n) ? rf[dst_n[2:0]] : opa;
        end
        carry_in = status_word[FLG_C];
        sat      = ctrl[CTRL_SAT];
        sum_s    = {{2{alu_a[31]}}, alu_a} + {{2{alu_b[31]}}, alu_b}
                   + {33'h0_0000_0000, carry_in};
        sum_u    = {1'h0, alu_a} + {1'h0, alu_b} + {32'h0000_0000, carry_in};
        b_neg    = 32'h0000_0000 - alu_b;
        ov       = 1'h0;
        res      = alu_b;
        unique case (op)
            OP_INT_ABS, OP_INT_ABS_STORE: begin
                ov  = alu_b == INT_MIN;
                if (ov) begin
                    res = sat ? INT_MAX : INT_MIN;
                end else begin
                    res = alu_b[31] ? b_neg : alu_b;
                end
            end
            OP_ADD_WITH_CARRY_OP, OP_THREE_OPERAND_ADD_CARRY_OP: begin
                ov  = sum_s[32] ^ sum_s[31];
                if (ov && sat) begin
                    res = sum_s[33] ? INT_MIN : INT_MAX;
                end else begin
                    res = sum_s[31:0];
                end
            end
            OP_FLOAT_ABS_STORE: begin
                ov  = (alu_b == INT_MIN) && (fexp == FEXP_MAX);
                res = ov ? INT_MAX : (alu_b[31] ? b_neg : alu_b);
            end
            default: begin
                ov  = 1'h0;
                res = alu_b;
            end
        endcase
        next_flags            = status_word;
        next_flags[FLG_LV]    = status_word[FLG_LV] | ov;
        next_flags[FLG_V]     = ov;
        next_flags[FLG_UF]    = 1'h0;
        next_flags[FLG_Z]     = (op == OP_FLOAT_ABS_STORE) ? (fexp == FEXP_ZERO)
                                                            : (res == 32'h0000_0000);
        if ((op == OP_ADD_WITH_CARRY_OP) || (op == OP_THREE_OPERAND_ADD_CARRY_OP)) begin
            next_flags[FLG_N] = res[31];
            next_flags[FLG_C] = sum_u[32];
        end else begin
            next_flags[FLG_N] = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_IDLE;
            busy     <= 1'h0;
            wait_cnt <= 8'h00;
        end else if (pce) begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_fire && chk[2]) begin
                        wait_cnt <= wait_load;
                        state    <= (wait_load == 8'h00) ? ST_EXEC : ST_FETCH;
                        busy     <= 1'h1;
                    end
                end
                ST_FETCH: begin
                    wait_cnt <= wait_cnt - 8'h01;
                    if (wait_cnt <= 8'h01) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                    busy  <= 1'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= CTRL_RST;
            opa    <= 32'h0000_0000;
            opb    <= 32'h0000_0000;
            cmd    <= 32'h0000_0000;
            adrcfg <= 9'h000;
            fexp   <= 8'h00;
        end else if (wr_fire) begin
            unique case (paddr)
                OFF_CTRL:   ctrl   <= pwdata[CTRL_W-1:0];
                OFF_OPA:    opa    <= pwdata;
                OFF_OPB:    opb    <= pwdata;
                OFF_CMD:    cmd    <= pwdata;
                OFF_ADRCFG: adrcfg <= pwdata[ADRCFG_W-1:0];
                OFF_FEXP:   fexp   <= pwdata[EXP_W-1:0];
                default:    ctrl   <= ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal_cmd <= 1'h0;
            last_mem    <= 2'h0;
        end else if (cmd_fire) begin
            illegal_cmd <= !chk[2];
            last_mem    <= chk[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word <= STATUS_RST;
        end else if (exec && ext_reg(dst_n)) begin
            status_word <= next_flags;
        end else if (wr_fire && (paddr == OFF_STATUS)) begin
            status_word <= pwdata[FLAGS_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // extended registers and result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < EXT_REGS; i++) begin
                rf[i] <= 32'h0000_0000;
            end
            result <= 32'h0000_0000;
        end else if (exec) begin
            result <= res;
            if (ext_reg(dst_n)) begin
                rf[dst_n[2:0]] <= res;
            end
        end else if (wr_fire && rf_hit) begin
            rf[rf_idx] <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parallel store port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_strobe <= 1'h0;
            store_value  <= 32'h0000_0000;
        end else if (pce) begin
            store_strobe <= exec && paired;
            if (exec && paired) begin
                store_value <= rf[src3_n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer, one wait state
    logic [DATA_W-1:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rf_hit) begin
            rd_word = rf[rf_idx];
        end else begin
            case (paddr)
                OFF_CTRL:   rd_word = {30'h0000_0000, ctrl};
                OFF_STATUS: rd_word = {25'h000_0000, status_word};
                OFF_OPA:    rd_word = opa;
                OFF_OPB:    rd_word = opb;
                OFF_CMD:    rd_word = cmd;
                OFF_ADRCFG: rd_word = {23'h00_0000, adrcfg};
                OFF_FEXP:   rd_word = {24'h00_0000, fexp};
                OFF_RESULT: rd_word = result;
                OFF_STORE:  rd_word = store_value;
                OFF_INFO:   rd_word = {28'h000_0000, busy, last_mem, illegal_cmd};
                default:    rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0000_0000;
        end else if (pce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'h1;
                pslverr <= !mapped || (pwrite && busy);
                prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
            end else begin
                pready  <= 1'h0;
                pslverr <= 1'h0;
            end
        end
    end

endmodule

/* File: iaa_apb_master.sv */
`timescale 1ns/1ps
module iaa_apb_master
    import iaa_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       pready,
    input  wire logic [iaa_pkg::DATA_W-1:0] prdata,
    input  wire logic                       pslverr,
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic      [iaa_pkg::ADDR_W-1:0] paddr,
    output logic      [iaa_pkg::DATA_W-1:0] pwdata,
    output logic                            hung
);
    initial begin
        {psel, penable, pwrite, hung} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        hung = (n >= 50);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* File: iaa_alu_chk.sv */
`timescale 1ns/1ps
module iaa_alu_chk
    import iaa_pkg::*;
#(
    parameter int unsigned MEM_WAIT = MEM_WAIT_DEF
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       pce,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [iaa_pkg::ADDR_W-1:0] paddr,
    input wire logic [iaa_pkg::DATA_W-1:0] pwdata,
    input wire logic                       pready,
    input wire logic [iaa_pkg::DATA_W-1:0] prdata,
    input wire logic                       pslverr,
    input wire logic                       store_strobe,
    input wire logic [iaa_pkg::DATA_W-1:0] store_value,
    input wire logic                       busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] busy_len;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_len <= 8'h00;
        end else if (!busy) begin
            busy_len <= 8'h00;
        end else if (pce) begin
            busy_len <= busy_len + 8'h01;
        end
    end

    sequence s_access_first;
        pce && psel && penable && !pready && !$past(penable);
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_ready_one_wait: assert property (s_access_first |=> s_answer)
        else $error("pready not one cycle after access start");
    a_ready_has_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access");
    a_rdata_zero: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0000_0000)
        else $error("read data not zero on write or error");
    a_err_misaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_busy_cause: assert property ($rose(busy) |-> $past(pready && pwrite && paddr == OFF_CMD))
        else $error("busy rose without a command write");
    a_busy_bounded: assert property (busy |-> busy_len <= 8'(2 * MEM_WAIT))
        else $error("command held busy too long");
    a_store_at_end: assert property (store_strobe |-> $past(busy) && !busy ##1 !store_strobe)
        else $error("store pulse not at end of execute");
    a_store_hold: assert property (!store_strobe |-> $stable(store_value))
        else $error("store value moved without a store");
endmodule

bind iaa_alu iaa_alu_chk #(.MEM_WAIT(MEM_WAIT)) u_chk (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .store_strobe(store_strobe), .store_value(store_value), .busy(busy)
);

/* File: int_abs_add_with_carry_op_alu_tb.sv */
`timescale 1ns/1ps
module int_abs_add_with_carry_op_alu_tb;
    import iaa_pkg::*;
    logic              pclk, presetn, pce, psel, penable, pwrite;
    logic              pready, pslverr, store_strobe, busy, hung, sat;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, store_value;
    logic [DATA_W-1:0] rf [8];
    logic [DATA_W-1:0] exp_store [$];
    logic [6:0]        st;
    int                miscompares, n_checks;

    iaa_alu #(.MEM_WAIT(1)) dut (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .store_strobe(store_strobe), .store_value(store_value), .busy(busy)
    );
    iaa_apb_master m (
        .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic ee, output logic [31:0] q);
        logic e;
        m.xfer(w, a, d, q, e);
        if (hung) begin
            miscompares++;
            tally_and_finish();
        end
        chk({31'h0, e}, {31'h0, ee});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xf(1'b1, a, d, 1'b0, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        xf(1'b0, a, 32'h0000_0000, ee, q);
        chk(q, exp);
    endtask

    task automatic load(input int k, input logic [31:0] v);
        rf[k] = v;
        wr(OFF_RF_BASE + 8'(4 * k), v);
    endtask

    task automatic run(input logic [31:0] c);
        int n;
        wr(OFF_CMD, c);
        n = 0;
        @(posedge pclk);
        while (busy === 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== 1'b0) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    function automatic logic [31:0] cmd(input int op, m1, m2, dst, s3, src, s1);
        return {3'h0, 5'(s1), 3'h0, 5'(src), 3'(s3), 5'(dst), 2'(m2), 2'(m1), 1'b0, 3'(op)};
    endfunction

    // reference absolute value and add with carry, flags into st
    function automatic logic [31:0] absm(input logic [31:0] s, input logic upd);
        logic v;
        logic [31:0] r;
        v = (s == INT_MIN);
        r = v ? (sat ? INT_MAX : INT_MIN) : (s[31] ? -s : s);
        if (upd) st = {st[6], st[5] | v, 1'b0, 1'b0, r == 0, v, st[0]};
        return r;
    endfunction

    function automatic logic [31:0] addm(input logic [31:0] a, b, input logic upd);
        logic [32:0] s;
        logic v;
        logic [31:0] r;
        s = {1'b0, a} + {1'b0, b} + {32'h0, st[0]};
        v = (a[31] == b[31]) && (s[31] != a[31]);
        r = (v && sat) ? (a[31] ? INT_MIN : INT_MAX) : s[31:0];
        if (upd) st = {st[6], st[5] | v, 1'b0, r[31], r == 0, v, s[32]};
        return r;
    endfunction

    always @(posedge pclk) begin
        if (store_strobe === 1'b1) begin
            if (exp_store.size() == 0) chk(32'h1, 32'h0);
            else chk(store_value, exp_store.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] a, b, r;
        {miscompares, n_checks} = 64'h0;
        {presetn, pce, sat} = 3'b010;
        st = 7'h00;
        a = $urandom(63132);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, 32'h0000_0000, 1'b0);
        rd(OFF_STATUS, 32'h0000_0000, 1'b0);
        rd(8'h30, 32'h0000_0000, 1'b1);
        rd(8'h42, 32'h0000_0000, 1'b1);
        for (int p = 0; p < 2; p++) begin
            sat = p[0];
            wr(OFF_CTRL, {30'h0, p[0], p[0]});
            wr(OFF_ADRCFG, 32'h0000_0000);
            st = 7'($urandom);
            wr(OFF_STATUS, {25'h0, st});
            for (int k = 0; k < 8; k++) load(k, $urandom);
            load(2, INT_MIN);
            load(3, 32'h0000_0000);
            load(4, {1'b1, 31'($urandom)});
            for (int k = 2; k < 5; k++) begin
                r = absm(rf[k], 1'b1);
                rf[k - 2] = r;
                run(cmd(1, 0, 0, k - 2, 0, k, 0));
                rd(OFF_RF_BASE + 8'(4 * (k - 2)), r, 1'b0);
                rd(OFF_STATUS, {25'h0, st}, 1'b0);
            end
            for (int m1 = 1; m1 < 4; m1++) begin
                b = $urandom;
                wr(OFF_OPB, b);
                rf[5] = absm(b, 1'b1);
                run(cmd(1, m1, 0, 5, 0, 0, 0));
                rd(OFF_RF_BASE + 8'h14, rf[5], 1'b0);
            end
            r = absm(rf[4], 1'b0);
            run(cmd(1, 0, 0, 9, 0, 4, 0));
            rd(OFF_RESULT, r, 1'b0);
            rd(OFF_STATUS, {25'h0, st}, 1'b0);
            load(6, 32'h7FFF_FF00 ^ 32'($urandom_range(255)));
            load(7, {p[0], 31'($urandom)});
            for (int k = 0; k < 2; k++) begin
                rf[6 - k] = addm(rf[6 - k], rf[7], 1'b1);
                run(cmd(3, 0, 0, 6 - k, 0, 7, 0));
                rd(OFF_RF_BASE + 8'(24 - 4 * k), rf[6 - k], 1'b0);
                rd(OFF_STATUS, {25'h0, st}, 1'b0);
            end
            a = $urandom;
            b = $urandom;
            wr(OFF_OPA, a);
            wr(OFF_OPB, b);
            r = addm(a, rf[7], 1'b0);
            run(cmd(3, 0, 0, 8, 0, 7, 0));
            rd(OFF_RESULT, r, 1'b0);
            for (int c = 0; c < 16; c++) begin
                rf[0] = addm(c[0] ? a : rf[1], c[3] ? b : rf[2], 1'b1);
                run(cmd(4, c % 4, c / 4, 0, 0, 2, 1));
                rd(OFF_RF_BASE, rf[0], 1'b0);
            end
            rd(OFF_STATUS, {25'h0, st}, 1'b0);
            wr(OFF_FEXP, 32'(FEXP_MAX));
            wr(OFF_OPB, INT_MIN);
            exp_store.push_back(rf[0]);
            rf[2] = INT_MAX;
            st = {st[6], 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, st[0]};
            run(cmd(5, 2, 0, 2, 0, 0, 0));
            rd(OFF_RF_BASE + 8'h08, INT_MAX, 1'b0);
            rd(OFF_STATUS, {25'h0, st}, 1'b0);
            if (p == 1) begin
                exp_store.push_back(rf[3]);
                rf[3] = absm(rf[4], 1'b1);
            end
            run(cmd(2, 0, 0, 3, 3, 4, 0));
            rd(OFF_RF_BASE + 8'h0C, rf[3], 1'b0);
            for (int k = 1; k < 6; k += 4) begin
                wr(OFF_ADRCFG, 32'(k));
                b = $urandom;
                wr(OFF_OPB, b);
                if (k == 1) begin
                    exp_store.push_back(rf[0]);
                    rf[1] = absm(b, 1'b1);
                end
                run(cmd(2, 2, 0, 1, 0, 0, 0));
                rd(OFF_RF_BASE + 8'h04, rf[1], 1'b0);
                rd(OFF_STATUS, {25'h0, st}, 1'b0);
            end
        end
        chk(32'(exp_store.size()), 32'h0000_0000);
        tally_and_finish();
    end
endmodule
